//--- rtl/rstwd_top.sv
// module: reset source combiner, delay counter, cause flags and watchdog timer
`timescale 1ns/1ps
module rstwd_top #(
	parameter int TOUT_W   = 20,
	parameter int WDT_BASE = rstwd_pkg::RSTWD_WDT_BASE,
	parameter int OSC_DIV  = rstwd_pkg::RSTWD_WDOSC_DIV
) (
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_rst_n,
	input  wire logic                    i_pin_reset_n,
	input  wire logic                    i_supply_low,
	input  wire logic                    i_scan_reset,
	input  wire logic [2:0]              i_brownout_level_fuse,
	input  wire logic                    i_watchdog_always_on_fuse,
	input  wire logic [TOUT_W-1:0]       i_timeout_cycles,
	input  wire logic                    i_wdt_restart,
	input  wire logic                    i_comparator_bandgap_select,
	input  wire logic                    i_adc_enable,
	input  wire rstwd_pkg::rstwd_wb_req_t i_wb,
	output logic [7:0]                   o_wb_dat,
	output logic                         o_wb_ack,
	output logic                         o_chip_reset,
	output logic                         o_bandgap_enable,
	output logic                         o_brownout_active
);
	import rstwd_pkg::*;

	localparam int WCW = $clog2(WDT_BASE) + 8;
	localparam int DVW = $clog2(OSC_DIV + 1);

	// fuse decode: only three codes enable the detector
	logic bod_en;
	assign bod_en = (i_brownout_level_fuse == RSTWD_BOD_LVL_LO)
		| (i_brownout_level_fuse == RSTWD_BOD_LVL_MID)
		| (i_brownout_level_fuse == RSTWD_BOD_LVL_HI);

	// supply-low persistence filter
	logic bod_filt;
	rstwd_filter #(
		.CYCLES(RSTWD_BOD_FILTER_CYC)
	) u_bod_filter (
		.i_sys_clk(i_sys_clk),
		.i_rst_n  (i_rst_n),
		.i_level  (i_supply_low & bod_en),
		.o_level  (bod_filt)
	);

	logic bod_src;
	assign bod_src = bod_filt & bod_en;

	// watchdog state
	logic       wde_q;
	logic [2:0] wdp_q;
	logic       watchdog_change_enable_q;
	logic [2:0] watchdog_change_enable_cnt_q;
	logic [WCW-1:0] wcnt_q;
	logic [DVW-1:0] div_q;
	logic       wdt_pulse_q;
	logic       chip_rst_q;
	logic [TOUT_W-1:0] tout_q;
	logic       por_done_q;
	logic       lvl2;
	assign lvl2 = i_watchdog_always_on_fuse;

	// any active source; pin and power-on stay a source for one clocked edge after
	// their async release, otherwise the delay counter would never load the time-out
	logic src_active;
	logic pin_seen_q;
	assign src_active = !i_pin_reset_n | pin_seen_q | !por_done_q | bod_src | i_scan_reset
		| wdt_pulse_q;

	// pin reset also forces reset asynchronously, so no clock is needed
	logic pin_async_rst_n;
	assign pin_async_rst_n = i_rst_n & i_pin_reset_n;

	// delay counter: loads while any source active, counts down after release
	always_ff @(posedge i_sys_clk or negedge pin_async_rst_n) begin
		if (!pin_async_rst_n) begin
			tout_q     <= '0;
			chip_rst_q <= 1'b1;
		end else if (src_active) begin
			tout_q     <= i_timeout_cycles;
			chip_rst_q <= 1'b1;
		end else if (tout_q != '0) begin
			tout_q     <= tout_q - TOUT_W'(1);
			chip_rst_q <= 1'b1;
		end else begin
			chip_rst_q <= 1'b0;
		end
	end

	assign o_chip_reset = chip_rst_q;

	// bus decode
	logic bus_hit;
	logic wr_stat;
	logic wr_ctl;
	assign bus_hit = i_wb.cyc & i_wb.stb & !o_wb_ack;
	assign wr_stat = bus_hit & i_wb.we & i_wb.sel & (i_wb.adr == RSTWD_ADDR_STATUS);
	assign wr_ctl  = bus_hit & i_wb.we & i_wb.sel & (i_wb.adr == RSTWD_ADDR_WDCTL);

	// cause flags: hardware set wins over software clear of the same bit
	logic [4:0] flags_q;
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flags_q    <= RSTWD_STATUS_RST[4:0];
			pin_seen_q <= 1'b0;
		end else begin
			pin_seen_q <= !i_pin_reset_n;
			for (int b = 0; b < 5; b++) begin
				if (wr_stat && !i_wb.dat[b])
					flags_q[b] <= 1'b0;
			end
			if (!i_pin_reset_n || pin_seen_q)
				flags_q[RSTWD_POS_PIN] <= 1'b1;
			if (bod_src)
				flags_q[RSTWD_POS_BOD] <= 1'b1;
			if (wdt_pulse_q)
				flags_q[RSTWD_POS_WDT] <= 1'b1;
			if (i_scan_reset)
				flags_q[RSTWD_POS_SCAN] <= 1'b1;
		end
	end

	// the watchdog is cleared on chip reset, disable, or restart command
	logic wdt_clr;
	logic wde_eff;
	assign wde_eff = wde_q | lvl2;
	assign wdt_clr = chip_rst_q | !wde_eff | i_wdt_restart;

	// watchdog control: timed sequence gates disable and period change
	logic wr_arm;
	assign wr_arm = wr_ctl & i_wb.dat[RSTWD_POS_WATCHDOG_CHANGE_ENABLE] & i_wb.dat[RSTWD_POS_WDE];
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wde_q      <= 1'b0;
			wdp_q      <= RSTWD_WDP_RST;
			watchdog_change_enable_q     <= 1'b0;
			watchdog_change_enable_cnt_q <= '0;
		end else if (chip_rst_q) begin
			wde_q      <= 1'b0;
			wdp_q      <= RSTWD_WDP_RST;
			watchdog_change_enable_q     <= 1'b0;
			watchdog_change_enable_cnt_q <= '0;
		end else if (wr_ctl && watchdog_change_enable_q) begin
			// second step of sequence; change-enable drops either way
			watchdog_change_enable_q <= 1'b0;
			if (!lvl2)
				wde_q <= i_wb.dat[RSTWD_POS_WDE];
			wdp_q <= i_wb.dat[2:0];
		end else if (wr_arm) begin
			watchdog_change_enable_q     <= 1'b1;
			watchdog_change_enable_cnt_q <= 3'(RSTWD_WATCHDOG_CHANGE_ENABLE_CYC);
			wde_q      <= 1'b1;
		end else begin
			if (wr_ctl && i_wb.dat[RSTWD_POS_WDE])
				wde_q <= 1'b1;
			if (watchdog_change_enable_q) begin
				if (watchdog_change_enable_cnt_q <= 3'h1)
					watchdog_change_enable_q <= 1'b0;
				watchdog_change_enable_cnt_q <= watchdog_change_enable_cnt_q - 3'h1;
			end
		end
	end

	// 1 MHz oscillator tick derived by divider from the system clock
	logic osc_tick;
	assign osc_tick = (div_q == DVW'(OSC_DIV - 1));
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			div_q <= '0;
		else if (osc_tick)
			div_q <= '0;
		else
			div_q <= div_q + DVW'(1);
	end

	// watchdog counter and one-clock expiry pulse
	logic [WCW-1:0] wlimit;
	assign wlimit = WCW'(WDT_BASE) << wdp_q;
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wcnt_q      <= '0;
			wdt_pulse_q <= 1'b0;
		end else if (wdt_clr) begin
			wcnt_q      <= '0;
			wdt_pulse_q <= 1'b0;
		end else if (osc_tick) begin
			if (wcnt_q >= wlimit - WCW'(1)) begin
				wcnt_q      <= '0;
				wdt_pulse_q <= 1'b1;
			end else begin
				wcnt_q      <= wcnt_q + WCW'(1);
				wdt_pulse_q <= 1'b0;
			end
		end else begin
			wdt_pulse_q <= 1'b0;
		end
	end

	// bus slave: single-cycle ack, unmapped reads return zero
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 8'h00;
		end else begin
			o_wb_ack <= bus_hit;
			if (bus_hit && !i_wb.we) begin
				case (i_wb.adr)
					RSTWD_ADDR_STATUS: o_wb_dat <= {3'h0, flags_q};
					RSTWD_ADDR_WDCTL:  o_wb_dat <= {3'h0, watchdog_change_enable_q, wde_eff, wdp_q};
					default:           o_wb_dat <= 8'h00;
				endcase
			end
		end
	end

	// bandgap enable and brown-out indicator, registered
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_bandgap_enable  <= 1'b0;
			o_brownout_active <= 1'b0;
			por_done_q        <= 1'b0;
		end else begin
			o_bandgap_enable  <= bod_en | i_comparator_bandgap_select | i_adc_enable;
			o_brownout_active <= bod_src;
			por_done_q        <= 1'b1;
		end
	end
endmodule : rstwd_top

//--- shared/rstwd_pkg.sv
// package: register map, field positions, timing constants and bus carriers for reset/watchdog
// What this block does
// - Pin held low past minimum width resets the chip, even without clock.
// - Pin release starts the delay counter; processor freed after time-out period.
// - Enabled brown-out resets at once; its release restarts after time-out delay.
// - Brown-out level from 3-bit fuse; 110, 101, 100 usable, others reserved.
// - Supply drop counts as brown-out only after about 2 us filter width.
// - Watchdog expiry gives one-clock reset pulse; delay starts at its falling edge.
// - Bit 4 flags scan-chain reset; cleared by power-on or writing zero.
// - Bit 3 flags watchdog reset; cleared by power-on or writing zero.
// - Bit 2 flags brown-out reset; cleared by power-on or writing zero.
// - Bit 1 flags pin reset; cleared by power-on or writing zero.
// - Bit 0 flags power-on reset; cleared only by writing zero.
// - Reference on when brown-out enabled, comparator select set, or converter enabled.
// - Watchdog counter counts a separate nominal 1 MHz oscillator tick; the code divides this tick down from the system clock.
// - Watchdog counter clears on restart, on disable, and on chip reset.
// - Eight selectable periods; unrestarted expiry resets the chip.
// - Fuse selects safety level: level 1 starts off, level 2 always on.
// - Watchdog control bits 7 to 5 read as zero.
// - Disable or period change only while change-enable set; it self-clears after four clocks.
// - Prescale codes 000 to 111 give 16K through 2048K oscillator cycles.
// - Timed sequence: write change-enable with enable, then new values within four cycles.
// - In level 2 the enable bit reads one and writes to it are ignored.
package rstwd_pkg;
	// register byte offsets on the wishbone slave
	localparam logic [3:0] RSTWD_ADDR_STATUS = 4'h0;
	localparam logic [3:0] RSTWD_ADDR_WDCTL  = 4'h4;
	// status field positions
	localparam int RSTWD_POS_POR  = 0;
	localparam int RSTWD_POS_PIN  = 1;
	localparam int RSTWD_POS_BOD  = 2;
	localparam int RSTWD_POS_WDT  = 3;
	localparam int RSTWD_POS_SCAN = 4;
	// watchdog control field positions
	localparam int RSTWD_POS_WATCHDOG_CHANGE_ENABLE = 4;
	localparam int RSTWD_POS_WDE  = 3;
	// reset values
	localparam logic [7:0] RSTWD_STATUS_RST = 8'h01;
	localparam logic [2:0] RSTWD_WDP_RST    = 3'h0;
	// brown-out level fuse codes
	localparam logic [2:0] RSTWD_BOD_LVL_LO  = 3'h6;
	localparam logic [2:0] RSTWD_BOD_LVL_MID = 3'h5;
	localparam logic [2:0] RSTWD_BOD_LVL_HI  = 3'h4;
	// timing
	localparam int RSTWD_CLK_MHZ        = 200;
	localparam int RSTWD_BOD_FILTER_NS  = 2000;
	localparam int RSTWD_BOD_FILTER_CYC = (RSTWD_BOD_FILTER_NS * RSTWD_CLK_MHZ + 999) / 1000;
	localparam int RSTWD_WDOSC_MHZ      = 1;
	localparam int RSTWD_WDOSC_DIV      = RSTWD_CLK_MHZ / RSTWD_WDOSC_MHZ;
	localparam int RSTWD_WATCHDOG_CHANGE_ENABLE_CYC       = 4;
	localparam int RSTWD_WDT_BASE       = 16384;
	// wishbone request carrier
	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [3:0] adr;
		logic       sel;
		logic [7:0] dat;
	} rstwd_wb_req_t;
endpackage : rstwd_pkg

//--- rtl/rstwd_filter.sv
// module: persistence filter, output rises only after input held high for a count
`timescale 1ns/1ps
module rstwd_filter #(
	parameter int CYCLES = 400
) (
	input  wire logic i_sys_clk,
	input  wire logic i_rst_n,
	input  wire logic i_level,
	output logic      o_level
);
	import rstwd_pkg::*;
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt_q;
	// counter saturates; any drop restarts the wait
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q   <= '0;
			o_level <= 1'b0;
		end else if (!i_level) begin
			cnt_q   <= '0;
			o_level <= 1'b0;
		end else if (cnt_q >= CW'(CYCLES - 1)) begin
			o_level <= 1'b1;
		end else begin
			cnt_q <= cnt_q + CW'(1);
		end
	end
endmodule : rstwd_filter

//--- verif/rstwd_top_sva.sv
// checker: port-level assertions for the reset and watchdog block
`timescale 1ns/1ps
module rstwd_top_sva #(
	parameter int TOUT_W = 20
) (
	input logic                   i_sys_clk,
	input logic                   i_rst_n,
	input logic                   i_pin_reset_n,
	input logic                   i_supply_low,
	input logic                   i_scan_reset,
	input logic [2:0]             i_brownout_level_fuse,
	input logic                   i_watchdog_always_on_fuse,
	input logic [TOUT_W-1:0]      i_timeout_cycles,
	input logic                   i_comparator_bandgap_select,
	input logic                   i_adc_enable,
	input rstwd_pkg::rstwd_wb_req_t i_wb,
	input logic [7:0]             o_wb_dat,
	input logic                   o_wb_ack,
	input logic                   o_chip_reset,
	input logic                   o_bandgap_enable,
	input logic                   o_brownout_active
);
	import rstwd_pkg::*;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	logic fuse_ok;
	int   quiet_q;
	int   low_q;
	assign fuse_ok = i_brownout_level_fuse inside {3'h4, 3'h5, 3'h6};
	// quiet time of pin, brown-out and scan sources and length of the current supply dip
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			quiet_q <= 0;
			low_q <= 0;
		end else begin
			quiet_q <= (!i_pin_reset_n || o_brownout_active || i_scan_reset) ? 0 : quiet_q + 1;
			low_q <= i_supply_low ? low_q + 1 : 0;
		end
	end
	AST_PIN_RST: assert property (!i_pin_reset_n |-> o_chip_reset)
		else $error("pin low without chip reset");
	AST_TOUT: assert property ($fell(o_chip_reset) |-> quiet_q >= i_timeout_cycles)
		else $error("chip reset released before delay");
	AST_BOD_FILT: assert property ($rose(o_brownout_active) |->
		fuse_ok && low_q >= RSTWD_BOD_FILTER_CYC - 1) else $error("brown-out too early");
	AST_BOD_RST: assert property (o_brownout_active |=> o_chip_reset)
		else $error("brown-out without chip reset");
	AST_SCAN_RST: assert property (i_scan_reset |-> ##[0:2] o_chip_reset)
		else $error("scan reset ignored");
	AST_BG: assert property (1'b1 |=>
		o_bandgap_enable == $past(fuse_ok || i_comparator_bandgap_select || i_adc_enable))
		else $error("reference enable wrong");
	AST_ACK: assert property (i_wb.cyc && i_wb.stb && !o_wb_ack |=> o_wb_ack)
		else $error("no ack one cycle after request");
	AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	AST_CTL_RD: assert property ($past(i_wb.cyc && !i_wb.we && i_wb.adr == RSTWD_ADDR_WDCTL)
		&& o_wb_ack |-> o_wb_dat[7:5] == 3'h0 && (o_wb_dat[3] || !i_watchdog_always_on_fuse))
		else $error("control read bits wrong");
endmodule : rstwd_top_sva
bind rstwd_top rstwd_top_sva #(.TOUT_W(TOUT_W)) u_sva (.i_sys_clk, .i_rst_n, .i_pin_reset_n,
	.i_supply_low, .i_scan_reset, .i_brownout_level_fuse, .i_watchdog_always_on_fuse,
	.i_timeout_cycles, .i_comparator_bandgap_select, .i_adc_enable, .i_wb, .o_wb_dat,
	.o_wb_ack, .o_chip_reset, .o_bandgap_enable, .o_brownout_active);

//--- verif/rstwd_partner.sv
// partner model: external reset pin, supply monitor and scan-chain reset level
`timescale 1ns/1ps
module rstwd_partner (
	input  logic i_sys_clk,
	output logic o_pin_reset_n,
	output logic o_supply_low,
	output logic o_scan_reset
);
	initial begin
		o_pin_reset_n = 1'b1;
		o_supply_low = 1'b0;
		o_scan_reset = 1'b0;
	end
	// hold one source active for n clocks, well past the pin and filter widths
	task automatic hold(input int src, input int n);
		@(posedge i_sys_clk);
		case (src)
			0: o_pin_reset_n <= 1'b0;
			1: o_supply_low <= 1'b1;
			default: o_scan_reset <= 1'b1;
		endcase
		repeat (n) @(posedge i_sys_clk);
		o_pin_reset_n <= 1'b1;
		o_supply_low <= 1'b0;
		o_scan_reset <= 1'b0;
	endtask : hold
endmodule : rstwd_partner

//--- verif/rstwd_top_tb.sv
// testbench: reset sources, cause flags and watchdog against a small model
`timescale 1ns/1ps
module rstwd_top_tb;
	import rstwd_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, restart = 1'b0, bgsel = 1'b0, adc = 1'b0, lvl2 = 1'b0;
	logic [2:0] fuse = 3'h0;
	logic [7:0] tout = 8'h0a;
	logic [7:0] rd, dat;
	logic ack, crst, bg, bact, pin_n, sup, scan;
	rstwd_wb_req_t wb_q = '0;
	logic [31:0] rnd = 32'h1c5e0711;
	int error_cnt = 0, checks_done = 0, m_wde = 0, m_wdp = 0, m_ce = 0, m_st = 1, n;
	// free-running 200 MHz clock
	always #2.5 clk = ~clk;
	rstwd_partner p (.i_sys_clk(clk), .o_pin_reset_n(pin_n), .o_supply_low(sup), .o_scan_reset(scan));
	rstwd_top #(.TOUT_W(8), .WDT_BASE(64), .OSC_DIV(2)) dut (.i_sys_clk(clk), .i_rst_n(rst_n),
		.i_pin_reset_n(pin_n), .i_supply_low(sup), .i_scan_reset(scan),
		.i_brownout_level_fuse(fuse), .i_watchdog_always_on_fuse(lvl2), .i_timeout_cycles(tout),
		.i_wdt_restart(restart), .i_comparator_bandgap_select(bgsel), .i_adc_enable(adc),
		.i_wb(wb_q), .o_wb_dat(dat), .o_wb_ack(ack), .o_chip_reset(crst), .o_bandgap_enable(bg),
		.o_brownout_active(bact));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	// one classic cycle; reference requests are randomised on the way
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		int k = 0;
		@(posedge clk);
		wb_q <= '{1'b1, 1'b1, w, a, 1'b1, d};
		bgsel <= rnd[0];
		adc <= rnd[1];
		rnd = xs(rnd);
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (k >= 20) error_cnt++;
		rd = dat;
		wb_q <= '0;
	endtask : wb
	task automatic rd_st();
		wb(1'b0, RSTWD_ADDR_STATUS, 8'h00);
		chk(rd, m_st[7:0]);
		chk({7'h0, bg}, {7'h0, bgsel | adc | (fuse inside {3'h4, 3'h5, 3'h6})});
		wb(1'b1, RSTWD_ADDR_STATUS, 8'h00);
		m_st = 0;
	endtask : rd_st
	task automatic rd_ctl();
		wb(1'b0, RSTWD_ADDR_WDCTL, 8'h00);
		chk(rd, {4'h0, m_wde[0], m_wdp[2:0]});
	endtask : rd_ctl
	// model: an open change window applies both fields, otherwise enable only sets
	task automatic wr_ctl(input logic [7:0] v);
		wb(1'b1, RSTWD_ADDR_WDCTL, v);
		if (m_ce != 0) begin
			m_wde = lvl2 | v[3];
			m_wdp = v[2:0];
			m_ce = 0;
		end else begin
			m_wde = m_wde | v[3];
			m_ce = v[4] & v[3];
		end
	endtask : wr_ctl
	// wait out the stretched reset, n keeps the edges it took; control returns to start
	task automatic settle();
		n = 0;
		while (crst !== 1'b0 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 5000) error_cnt++;
		m_wde = lvl2;
		m_wdp = 0;
		m_ce = 0;
	endtask : settle
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		rd_st();
		rd_st();
		p.hold(0, 20);
		settle();
		m_st = 2;
		rd_st();
		for (int i = 3; i >= 0; i--) begin
			fuse <= (i == 0) ? 3'h0 : 3'(3 + i);
			p.hold(1, 420);
			settle();
			m_st = (i == 0) ? 0 : 4;
			rd_st();
		end
		p.hold(2, 5);
		settle();
		m_st = 16;
		rd_st();
		wr_ctl(8'h0f);
		rd_ctl();
		wr_ctl(8'h18);
		wr_ctl(8'h03);
		rd_ctl();
		wr_ctl(8'h08);
		wr_ctl(8'h00);
		rd_ctl();
		wr_ctl(8'h1b);
		repeat (8) @(posedge clk);
		m_ce = 0;
		wr_ctl(8'h00);
		rd_ctl();
		n = 0;
		while (crst !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk({7'h0, n > 900 && n < 1100}, 8'h01);
		settle();
		m_st = 8;
		rd_st();
		rd_ctl();
		wr_ctl(8'h08);
		repeat (40) begin
			rnd = xs(rnd);
			repeat (int'(rnd[5:0]) + 1) @(posedge clk);
			restart <= 1'b1;
			@(posedge clk);
			restart <= 1'b0;
			chk({7'h0, crst}, 8'h00);
		end
		wr_ctl(8'h18);
		wr_ctl(8'h00);
		rd_ctl();
		lvl2 <= 1'b1;
		p.hold(0, 5);
		settle();
		rd_ctl();
		wr_ctl(8'h18);
		wr_ctl(8'h05);
		rd_ctl();
		// second power-on mid-run with a fresh random delay length
		rnd = xs(rnd);
		tout <= 8'h10 | {4'h0, rnd[3:0]};
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		chk({7'h0, n > int'(tout) && n < int'(tout) + 5}, 8'h01);
		m_st = 1;
		rd_st();
		rd_ctl();
		conclude();
	end
	// hang guard
	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		conclude();
	end
endmodule : rstwd_top_tb
